// ### core/vhf_map.svh
`ifndef VHF_MAP_SVH
`define VHF_MAP_SVH

// object indices
`define VHF_IDX_HOTSHOT     16'h2220
`define VHF_IDX_HOLD        16'h2221
`define VHF_IDX_PEAK_TIME   16'h2222
`define VHF_IDX_BLINK       16'h2223
`define VHF_IDX_OVERRIDE    16'h2300
`define VHF_IDX_FAULT_EN    16'h2310
`define VHF_IDX_FAULT_TOL   16'h2311
`define VHF_IDX_FAULT_DLY   16'h2312
`define VHF_IDX_STATUS      16'h23f0

// sub-index layout
`define VHF_SUB_COUNT       8'h00
`define VHF_SUB_CH1         8'h01
`define VHF_SUB_CH2         8'h02
`define VHF_NUM_SUB         16'h0002

// reset values
`define VHF_RST_HOTSHOT     16'h07d0
`define VHF_RST_HOLD        16'h01f4
`define VHF_RST_PEAK_TIME   16'h03e8
`define VHF_RST_BLINK       16'h01f4
`define VHF_RST_OVERRIDE    16'h02ee
`define VHF_RST_FAULT_EN    1'b1
`define VHF_RST_FAULT_TOL   16'h0064
`define VHF_RST_FAULT_DLY   16'h03e8

// ranges
`define VHF_MAX_TIME_MS     16'hea60
`define VHF_TOL_DIV         17'h0000a

// status word bit positions
`define VHF_ST_DRIVE_ON     0
`define VHF_ST_HOLD_PHASE   1
`define VHF_ST_PEAK_PHASE   2
`define VHF_ST_FAULT        3

// timing
`define VHF_CLK_NS          10
`define VHF_MS_NS           1000000
`define VHF_CYC_PER_MS      (`VHF_MS_NS / `VHF_CLK_NS)

`endif

// ### core/vhf_pkg.sv
package vhf_pkg;
    typedef enum logic [1:0] {
        MODE_ANALOG,
        MODE_ONOFF,
        MODE_BLINK,
        MODE_HOTSHOT
    } vhf_mode_t;

    typedef enum logic [1:0] {
        PH_OFF,
        PH_PEAK,
        PH_HOLD
    } vhf_phase_t;
endpackage

// ### core/vhf_cfg_if.sv
interface vhf_cfg_if;
    logic signed [15:0] hotshot_cur;
    logic signed [15:0] hold_cur;
    logic        [15:0] peak_time;
    logic        [15:0] blink_period;
    logic signed [15:0] override_level;
    logic               fault_en;
    logic signed [15:0] fault_tol;
    logic        [15:0] fault_delay;

    modport src (output hotshot_cur, hold_cur, peak_time, blink_period, override_level, fault_en, fault_tol,
                 fault_delay);
    modport dst (input hotshot_cur, hold_cur, peak_time, blink_period, override_level, fault_en, fault_tol,
                 fault_delay);
endinterface

// ### core/vhf_tick.sv
`include "vhf_map.svh"

module vhf_tick #(
    parameter int CYC_PER_MS = `VHF_CYC_PER_MS
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    output logic      tick
);
    logic [31:0] div_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_reg <= 32'h0;
            tick    <= 1'b0;
        end else if (div_reg >= 32'(CYC_PER_MS - 1)) begin
            div_reg <= 32'h0;
            tick    <= 1'b1;
        end else begin
            div_reg <= div_reg + 32'h1;
            tick    <= 1'b0;
        end
    end

    chk_tick_single: assert property (@(posedge clk_sys) disable iff (rst)
        (CYC_PER_MS > 1) && tick |=> !tick)
        else $error("tick lasted more than one cycle");
endmodule

// ### core/vhf_chan.sv
`include "vhf_map.svh"

module vhf_chan
    import vhf_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               tick,
    vhf_cfg_if.dst                  cfg,
    input  wire vhf_mode_t          mode,
    input  wire logic               cmd_on,
    input  wire logic               override_act,
    input  wire logic signed [15:0] target,
    input  wire logic signed [15:0] feedback,
    output logic signed [15:0]      drive_level,
    output logic                    drive_on,
    output logic                    fault_active,
    output logic                    emcy_pulse,
    output vhf_phase_t              phase
);
    logic        [15:0] hs_cnt_reg;
    logic        [15:0] blink_cnt_reg;
    logic               blink_on_reg;
    logic        [15:0] flt_cnt_reg;
    logic signed [16:0] diff;
    logic        [16:0] diff_abs;
    logic               fault_raw;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase      <= PH_OFF;
            hs_cnt_reg <= 16'h0;
        end else if (mode != MODE_HOTSHOT || !cmd_on) begin
            phase      <= PH_OFF;
            hs_cnt_reg <= 16'h0;
        end else begin
            case (phase)
                PH_OFF: begin
                    phase      <= (cfg.peak_time == 16'h0) ? PH_HOLD : PH_PEAK;
                    hs_cnt_reg <= 16'h0;
                end
                PH_PEAK: begin
                    if (tick) begin
                        if (17'(hs_cnt_reg) + 17'h1 >= 17'(cfg.peak_time)) begin
                            phase <= PH_HOLD;
                        end else begin
                            hs_cnt_reg <= hs_cnt_reg + 16'h1;
                        end
                    end
                end
                PH_HOLD: begin
                    phase <= PH_HOLD;
                end
                default: begin
                    phase <= PH_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            blink_cnt_reg <= 16'h0;
            blink_on_reg  <= 1'b1;
        end else if (mode != MODE_BLINK || !cmd_on || cfg.blink_period == 16'h0) begin
            blink_cnt_reg <= 16'h0;
            blink_on_reg  <= 1'b1;
        end else if (tick) begin
            if (17'(blink_cnt_reg) + 17'h1 >= 17'(cfg.blink_period)) begin
                blink_cnt_reg <= 16'h0;
                blink_on_reg  <= !blink_on_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 16'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drive_level <= 16'sh0;
            drive_on    <= 1'b0;
        end else begin
            drive_on <= cmd_on && (mode != MODE_BLINK || blink_on_reg);
            if (override_act) begin
                drive_level <= cfg.override_level;
            end else begin
                case (mode)
                    MODE_HOTSHOT: drive_level <= (phase == PH_PEAK) ? cfg.hotshot_cur :
                                                 (phase == PH_HOLD) ? cfg.hold_cur : 16'sh0;
                    MODE_BLINK:   drive_level <= (cmd_on && blink_on_reg) ? target : 16'sh0;
                    MODE_ONOFF:   drive_level <= cmd_on ? target : 16'sh0;
                    default:      drive_level <= target;
                endcase
            end
        end
    end

    assign diff      = 17'(drive_level) - 17'(feedback);
    assign diff_abs  = diff[16] ? 17'(-diff) : 17'(diff);
    assign fault_raw = diff_abs > 17'(cfg.fault_tol);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flt_cnt_reg  <= 16'h0;
            fault_active <= 1'b0;
            emcy_pulse   <= 1'b0;
        end else begin
            emcy_pulse <= 1'b0;
            if (!fault_raw) begin
                flt_cnt_reg  <= 16'h0;
                fault_active <= 1'b0;
            end else if (!fault_active) begin
                if (flt_cnt_reg >= cfg.fault_delay) begin
                    fault_active <= 1'b1;
                    emcy_pulse   <= cfg.fault_en;
                end else if (tick) begin
                    flt_cnt_reg <= flt_cnt_reg + 16'h1;
                end
            end
        end
    end

    chk_hold_level: assert property (@(posedge clk_sys) disable iff (rst)
        phase == PH_HOLD && !override_act && mode == MODE_HOTSHOT |=> drive_level == $past(cfg.hold_cur))
        else $error("hold current not driven after peak");
    chk_peak_exit: assert property (@(posedge clk_sys) disable iff (rst)
        phase == PH_PEAK && tick && cmd_on && mode == MODE_HOTSHOT && 17'(hs_cnt_reg) + 17'h1 >= 17'(cfg.peak_time)
        |=> phase == PH_HOLD)
        else $error("peak phase did not end at its time");
    chk_blink_toggle: assert property (@(posedge clk_sys) disable iff (rst)
        mode == MODE_BLINK && cmd_on && tick && cfg.blink_period != 16'h0 &&
        17'(blink_cnt_reg) + 17'h1 >= 17'(cfg.blink_period) |=> blink_on_reg != $past(blink_on_reg))
        else $error("blink did not toggle at period end");
    chk_blink_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        mode == MODE_HOTSHOT |=> blink_on_reg && blink_cnt_reg == 16'h0)
        else $error("blink state moved in hotshot mode");
    chk_override_level: assert property (@(posedge clk_sys) disable iff (rst)
        override_act |=> drive_level == $past(cfg.override_level))
        else $error("override level not applied");
    chk_emcy_gate: assert property (@(posedge clk_sys) disable iff (rst)
        emcy_pulse |-> $past(cfg.fault_en) && $rose(fault_active))
        else $error("emergency raised while detection disabled");
    chk_fault_cause: assert property (@(posedge clk_sys) disable iff (rst)
        fault_active |-> $past(fault_raw))
        else $error("fault shown without deviation");
    chk_fault_delay: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(fault_active) |-> $past(flt_cnt_reg) >= $past(cfg.fault_delay))
        else $error("fault recognised before reaction delay");
    chk_hotshot_restart: assert property (@(posedge clk_sys) disable iff (rst)
        !cmd_on |=> phase == PH_OFF && hs_cnt_reg == 16'h0)
        else $error("hotshot phase kept across turn-off");
endmodule

// ### core/vhf_top.sv
`include "vhf_map.svh"

module vhf_top
    import vhf_pkg::*;
#(
    parameter int CYC_PER_MS = `VHF_CYC_PER_MS
) (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               od_req,
    input  wire logic               od_wr,
    input  wire logic        [15:0] od_index,
    input  wire logic        [7:0]  od_sub,
    input  wire logic        [15:0] od_wdata,
    output logic                    od_ack,
    output logic                    od_abort,
    output logic             [15:0] od_rdata,
    input  wire logic        [1:0]  chan_mode [2],
    input  wire logic        [1:0]  ctrl_on,
    input  wire logic        [1:0]  override_act,
    input  wire logic signed [15:0] ctrl_target [2],
    input  wire logic signed [15:0] feedback [2],
    input  wire logic        [15:0] out_max_a,
    input  wire logic        [15:0] out_max_b,
    output logic signed      [15:0] drive_level [2],
    output logic             [1:0]  drive_on,
    output logic             [1:0]  fault_active,
    output logic             [1:0]  emcy_pulse
);
    logic               tick;
    logic signed [15:0] hotshot_reg [2];
    logic signed [15:0] hold_reg [2];
    logic        [15:0] peak_time_reg [2];
    logic        [15:0] blink_reg [2];
    logic signed [15:0] override_reg [2];
    logic               fault_en_reg [2];
    logic signed [15:0] fault_tol_reg [2];
    logic        [15:0] fault_dly_reg [2];
    vhf_phase_t         phase [2];

    logic               ch;
    logic               sub_ok;
    logic               known;
    logic               wr_ok;
    logic               abort_next;
    logic        [15:0] rd_val;
    logic        [16:0] tol_limit;
    logic signed [15:0] wsig;
    logic               wr_go;

    vhf_cfg_if cfg [2] ();

    vhf_tick #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (tick)
    );

    assign wsig      = od_wdata;
    assign ch        = (od_sub == `VHF_SUB_CH2);
    assign sub_ok    = (od_sub == `VHF_SUB_CH1) || (od_sub == `VHF_SUB_CH2);
    assign tol_limit = ((out_max_a > out_max_b) ? 17'(out_max_a) : 17'(out_max_b)) / `VHF_TOL_DIV;

    // object decode and range checks
    always_comb begin
        known  = 1'b1;
        wr_ok  = 1'b0;
        rd_val = 16'h0;
        case (od_index)
            `VHF_IDX_HOTSHOT: begin
                rd_val = hotshot_reg[ch];
                wr_ok  = !wsig[15] && (wsig >= hold_reg[ch]);
            end
            `VHF_IDX_HOLD: begin
                rd_val = hold_reg[ch];
                wr_ok  = !wsig[15] && (wsig <= hotshot_reg[ch]);
            end
            `VHF_IDX_PEAK_TIME: begin
                rd_val = peak_time_reg[ch];
                wr_ok  = od_wdata <= `VHF_MAX_TIME_MS;
            end
            `VHF_IDX_BLINK: begin
                rd_val = blink_reg[ch];
                wr_ok  = od_wdata <= `VHF_MAX_TIME_MS;
            end
            `VHF_IDX_OVERRIDE: begin
                rd_val = override_reg[ch];
                wr_ok  = 1'b1;
            end
            `VHF_IDX_FAULT_EN: begin
                rd_val = {15'h0, fault_en_reg[ch]};
                wr_ok  = od_wdata <= 16'h0001;
            end
            `VHF_IDX_FAULT_TOL: begin
                rd_val = fault_tol_reg[ch];
                wr_ok  = !wsig[15] && (17'(od_wdata) <= tol_limit);
            end
            `VHF_IDX_FAULT_DLY: begin
                rd_val = fault_dly_reg[ch];
                wr_ok  = od_wdata <= `VHF_MAX_TIME_MS;
            end
            `VHF_IDX_STATUS: begin
                rd_val                     = 16'h0;
                rd_val[`VHF_ST_DRIVE_ON]   = drive_on[ch];
                rd_val[`VHF_ST_HOLD_PHASE] = (phase[ch] == PH_HOLD);
                rd_val[`VHF_ST_PEAK_PHASE] = (phase[ch] == PH_PEAK);
                rd_val[`VHF_ST_FAULT]      = fault_active[ch];
                wr_ok                      = 1'b0;
            end
            default: begin
                known = 1'b0;
            end
        endcase
        if (od_sub == `VHF_SUB_COUNT) begin
            rd_val     = `VHF_NUM_SUB;
            abort_next = !known || od_wr;
        end else begin
            abort_next = !known || !sub_ok || (od_wr && !wr_ok);
        end
    end

    assign wr_go = od_req && od_wr && !abort_next;

    // object access answer, one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            od_ack   <= 1'b0;
            od_abort <= 1'b0;
            od_rdata <= 16'h0;
        end else begin
            od_ack   <= od_req;
            od_abort <= od_req && abort_next;
            od_rdata <= (od_req && !od_wr && !abort_next) ? rd_val : 16'h0;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_chan
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                hotshot_reg[g]   <= `VHF_RST_HOTSHOT;
                hold_reg[g]      <= `VHF_RST_HOLD;
                peak_time_reg[g] <= `VHF_RST_PEAK_TIME;
                blink_reg[g]     <= `VHF_RST_BLINK;
                override_reg[g]  <= `VHF_RST_OVERRIDE;
                fault_en_reg[g]  <= `VHF_RST_FAULT_EN;
                fault_tol_reg[g] <= `VHF_RST_FAULT_TOL;
                fault_dly_reg[g] <= `VHF_RST_FAULT_DLY;
            end else if (wr_go && ch == 1'(g)) begin
                case (od_index)
                    `VHF_IDX_HOTSHOT:   hotshot_reg[g]   <= wsig;
                    `VHF_IDX_HOLD:      hold_reg[g]      <= wsig;
                    `VHF_IDX_PEAK_TIME: peak_time_reg[g] <= od_wdata;
                    `VHF_IDX_BLINK:     blink_reg[g]     <= od_wdata;
                    `VHF_IDX_OVERRIDE:  override_reg[g]  <= wsig;
                    `VHF_IDX_FAULT_EN:  fault_en_reg[g]  <= od_wdata[0];
                    `VHF_IDX_FAULT_TOL: fault_tol_reg[g] <= wsig;
                    `VHF_IDX_FAULT_DLY: fault_dly_reg[g] <= od_wdata;
                    default:            hold_reg[g]      <= hold_reg[g];
                endcase
            end
        end

        assign cfg[g].hotshot_cur    = hotshot_reg[g];
        assign cfg[g].hold_cur       = hold_reg[g];
        assign cfg[g].peak_time      = peak_time_reg[g];
        assign cfg[g].blink_period   = blink_reg[g];
        assign cfg[g].override_level = override_reg[g];
        assign cfg[g].fault_en       = fault_en_reg[g];
        assign cfg[g].fault_tol      = fault_tol_reg[g];
        assign cfg[g].fault_delay    = fault_dly_reg[g];

        vhf_chan u_chan (
            .clk_sys      (clk_sys),
            .rst          (rst),
            .tick         (tick),
            .cfg          (cfg[g]),
            .mode         (vhf_mode_t'(chan_mode[g])),
            .cmd_on       (ctrl_on[g]),
            .override_act (override_act[g]),
            .target       (ctrl_target[g]),
            .feedback     (feedback[g]),
            .drive_level  (drive_level[g]),
            .drive_on     (drive_on[g]),
            .fault_active (fault_active[g]),
            .emcy_pulse   (emcy_pulse[g]),
            .phase        (phase[g])
        );

        chk_hold_bound: assert property (@(posedge clk_sys) disable iff (rst)
            hold_reg[g] <= hotshot_reg[g] && !hold_reg[g][15])
            else $error("hold current above hotshot current");
    end

    // a refused write leaves the stored value untouched, so the hold <= hotshot bound holds at all times
    chk_tol_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        od_req && od_wr && od_index == `VHF_IDX_FAULT_TOL && sub_ok && 17'(od_wdata) > tol_limit
        |=> od_ack && od_abort)
        else $error("tolerance above tenth of limit accepted");
    chk_hold_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        od_req && od_wr && od_index == `VHF_IDX_HOLD && sub_ok && wsig > hotshot_reg[ch]
        |=> od_abort && hold_reg[0] == $past(hold_reg[0]) && hold_reg[1] == $past(hold_reg[1]))
        else $error("hold write above hotshot accepted");
endmodule

// ### testbench/vhf_coil_model.sv
module vhf_coil_model (
    input  wire logic        [1:0]  open_load,
    input  wire logic signed [15:0] drive_level [2],
    output logic signed      [15:0] feedback [2]
);
    timeunit 1ns;
    timeprecision 1ps;

    // healthy coil: sensed current tracks command with no lag, so no false faults
    // open coil reads zero current whatever is commanded
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            feedback[i] = open_load[i] ? 16'sh0000 : drive_level[i];
        end
    end
endmodule

// ### testbench/testbench.sv
`include "vhf_map.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end

module testbench
    import vhf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk_sys = 1'b0;
    logic               rst = 1'b1;
    logic               od_req = 1'b0;
    logic               od_wr = 1'b0;
    logic        [15:0] od_index = 16'h0000;
    logic        [7:0]  od_sub = 8'h00;
    logic        [15:0] od_wdata = 16'h0000;
    logic               od_ack;
    logic               od_abort;
    logic        [15:0] od_rdata;
    logic        [1:0]  chan_mode [2] = '{2'h0, 2'h0};
    logic        [1:0]  ctrl_on = 2'h0;
    logic        [1:0]  override_act = 2'h0;
    logic signed [15:0] ctrl_target [2] = '{16'sh0000, 16'sh0000};
    logic signed [15:0] feedback [2];
    logic signed [15:0] drive_level [2];
    logic        [1:0]  drive_on;
    logic        [1:0]  fault_active;
    logic        [1:0]  emcy_pulse;
    logic        [1:0]  open_load = 2'h0;
    int                 checks = 0;
    int                 bad_count = 0;
    int                 emcy_cnt [2] = '{0, 0};
    int                 n;
    int                 e0;
    logic               ok;
    logic        [15:0] idx_tab [8] = '{`VHF_IDX_HOTSHOT, `VHF_IDX_HOLD, `VHF_IDX_PEAK_TIME, `VHF_IDX_BLINK,
                                        `VHF_IDX_OVERRIDE, `VHF_IDX_FAULT_EN, `VHF_IDX_FAULT_TOL, `VHF_IDX_FAULT_DLY};
    logic        [15:0] rst_tab [8] = '{16'h07d0, 16'h01f4, 16'h03e8, 16'h01f4, 16'h02ee, 16'h0001, 16'h0064,
                                        16'h03e8};

    vhf_top #(.CYC_PER_MS(10)) vhf_top_inst (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .od_req       (od_req),
        .od_wr        (od_wr),
        .od_index     (od_index),
        .od_sub       (od_sub),
        .od_wdata     (od_wdata),
        .od_ack       (od_ack),
        .od_abort     (od_abort),
        .od_rdata     (od_rdata),
        .chan_mode    (chan_mode),
        .ctrl_on      (ctrl_on),
        .override_act (override_act),
        .ctrl_target  (ctrl_target),
        .feedback     (feedback),
        .out_max_a    (16'h03e8),
        .out_max_b    (16'h07d0),
        .drive_level  (drive_level),
        .drive_on     (drive_on),
        .fault_active (fault_active),
        .emcy_pulse   (emcy_pulse)
    );

    vhf_coil_model vhf_coil_model_inst (
        .open_load   (open_load),
        .drive_level (drive_level),
        .feedback    (feedback)
    );

    always #5 clk_sys = ~clk_sys;

    // sampled on the falling edge so the count never races the design's update
    always @(negedge clk_sys) begin
        if (emcy_pulse[0] === 1'b1) emcy_cnt[0]++;
        if (emcy_pulse[1] === 1'b1) emcy_cnt[1]++;
    end

    task automatic end_sim();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // answer is fixed one cycle after the request edge
    task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] wd,
                      input logic ab, input logic [15:0] rd);
        @(negedge clk_sys);
        od_req = 1'b1;
        od_wr = wr;
        od_index = idx;
        od_sub = sub;
        od_wdata = wd;
        @(negedge clk_sys);
        od_req = 1'b0;
        `CHK(od_ack, 1'b1)
        `CHK(od_abort, ab)
        if (!wr && !ab) `CHK(od_rdata, rd)
    endtask

    task automatic wait_for(input int sel, input int ch, input logic [15:0] v, input int lim, output int cnt);
        logic hit;
        cnt = 0;
        hit = 1'b0;
        while (!hit && cnt < lim) begin
            @(negedge clk_sys);
            cnt++;
            case (sel)
                0: hit = (drive_level[ch] === v);
                1: hit = (drive_on[ch] === v[0]);
                default: hit = (fault_active[ch] === v[0]);
            endcase
        end
        if (!hit) begin
            bad_count++;
            $display("[FAIL] %0t wait ran out", $time);
            end_sim();
        end
    endtask

    task automatic t_defaults();
        for (int i = 0; i < 8; i++) begin
            od(1'b0, idx_tab[i], 8'h00, 16'h0000, 1'b0, 16'h0002);
            od(1'b0, idx_tab[i], 8'h01, 16'h0000, 1'b0, rst_tab[i]);
            od(1'b0, idx_tab[i], 8'h02, 16'h0000, 1'b0, rst_tab[i]);
        end
        od(1'b0, 16'h2224, 8'h01, 16'h0000, 1'b1, 16'h0000);
        od(1'b1, `VHF_IDX_STATUS, 8'h01, 16'h0001, 1'b1, 16'h0000);
        od(1'b1, `VHF_IDX_HOLD, 8'h00, 16'h0001, 1'b1, 16'h0000);
        $display("t_defaults done");
    endtask

    task automatic t_ranges();
        od(1'b1, `VHF_IDX_HOLD, 8'h01, 16'h07d1, 1'b1, 16'h0000);
        od(1'b1, `VHF_IDX_HOLD, 8'h01, 16'hffff, 1'b1, 16'h0000);
        od(1'b1, `VHF_IDX_HOLD, 8'h01, 16'h07d0, 1'b0, 16'h0000);
        od(1'b0, `VHF_IDX_HOLD, 8'h01, 16'h0000, 1'b0, 16'h07d0);
        od(1'b1, `VHF_IDX_HOLD, 8'h01, 16'h01f4, 1'b0, 16'h0000);
        od(1'b1, `VHF_IDX_HOTSHOT, 8'h02, 16'h01f3, 1'b1, 16'h0000);
        od(1'b1, `VHF_IDX_PEAK_TIME, 8'h01, 16'hea61, 1'b1, 16'h0000);
        od(1'b1, `VHF_IDX_PEAK_TIME, 8'h02, 16'hea60, 1'b0, 16'h0000);
        od(1'b0, `VHF_IDX_PEAK_TIME, 8'h02, 16'h0000, 1'b0, 16'hea60);
        od(1'b1, `VHF_IDX_BLINK, 8'h01, 16'hea61, 1'b1, 16'h0000);
        od(1'b1, `VHF_IDX_FAULT_EN, 8'h01, 16'h0002, 1'b1, 16'h0000);
        od(1'b1, `VHF_IDX_FAULT_TOL, 8'h01, 16'h00c9, 1'b1, 16'h0000);
        od(1'b1, `VHF_IDX_FAULT_TOL, 8'h01, 16'h00c8, 1'b0, 16'h0000);
        od(1'b0, `VHF_IDX_FAULT_TOL, 8'h01, 16'h0000, 1'b0, 16'h00c8);
        $display("t_ranges done");
    endtask

    task automatic t_hotshot();
        od(1'b1, `VHF_IDX_PEAK_TIME, 8'h01, 16'h0003, 1'b0, 16'h0000);
        od(1'b1, `VHF_IDX_BLINK, 8'h01, 16'h0001, 1'b0, 16'h0000);
        ctrl_target[1] = 16'sh0123;
        chan_mode[0] = MODE_HOTSHOT;
        ctrl_on[0] = 1'b1;
        wait_for(0, 0, 16'h07d0, 5, n);
        wait_for(0, 0, 16'h01f4, 40, n);
        `CHK(n >= 19 && n <= 31, 1'b1)
        ok = 1'b1;
        repeat (30) begin
            @(negedge clk_sys);
            if (drive_level[0] !== 16'sh01f4 || drive_on[0] !== 1'b1) ok = 1'b0;
        end
        `CHK(ok, 1'b1)
        od(1'b0, `VHF_IDX_STATUS, 8'h01, 16'h0000, 1'b0, 16'h0003);
        `CHK(drive_level[1], 16'sh0123)
        ctrl_on[0] = 1'b0;
        @(negedge clk_sys);
        ctrl_on[0] = 1'b1;
        wait_for(0, 0, 16'h07d0, 5, n);
        `CHK(drive_level[0], 16'sh07d0)
        od(1'b0, `VHF_IDX_STATUS, 8'h01, 16'h0000, 1'b0, 16'h0005);
        wait_for(0, 0, 16'h01f4, 40, n);
        `CHK(drive_on[0], 1'b1)
        ctrl_on[0] = 1'b0;
        chan_mode[0] = MODE_ANALOG;
        $display("t_hotshot done");
    endtask

    task automatic t_blink();
        od(1'b1, `VHF_IDX_BLINK, 8'h02, 16'h0002, 1'b0, 16'h0000);
        ctrl_target[1] = 16'sh012c;
        chan_mode[1] = MODE_BLINK;
        ctrl_on[1] = 1'b1;
        wait_for(1, 1, 16'h0000, 40, n);
        wait_for(1, 1, 16'h0001, 40, n);
        `CHK(n, 20)
        wait_for(1, 1, 16'h0000, 40, n);
        `CHK(n, 20)
        ctrl_on[1] = 1'b0;
        chan_mode[1] = MODE_ANALOG;
        ctrl_target[1] = 16'sh0000;
        $display("t_blink done");
    endtask

    task automatic t_override();
        od(1'b1, `VHF_IDX_OVERRIDE, 8'h01, 16'h0258, 1'b0, 16'h0000);
        override_act[0] = 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK(drive_level[0], 16'sh0258)
        override_act[0] = 1'b0;
        chan_mode[1] = MODE_ONOFF;
        ctrl_target[1] = 16'sh0150;
        ctrl_on[1] = 1'b1;
        repeat (3) @(negedge clk_sys);
        ok = 1'b1;
        repeat (30) begin
            @(negedge clk_sys);
            if (drive_level[1] !== 16'sh0150 || drive_on[1] !== 1'b1) ok = 1'b0;
        end
        `CHK(ok, 1'b1)
        ctrl_on[1] = 1'b0;
        chan_mode[1] = MODE_ANALOG;
        ctrl_target[1] = 16'sh0000;
        repeat (3) @(negedge clk_sys);
        $display("t_override done");
    endtask

    task automatic t_fault();
        od(1'b1, `VHF_IDX_FAULT_DLY, 8'h01, 16'h0003, 1'b0, 16'h0000);
        ctrl_target[0] = 16'sh00c8;
        @(negedge clk_sys);
        open_load[0] = 1'b1;
        repeat (60) @(negedge clk_sys);
        `CHK(fault_active[0], 1'b0)
        e0 = emcy_cnt[0];
        ctrl_target[0] = 16'sh00c9;
        wait_for(2, 0, 16'h0001, 45, n);
        `CHK(n >= 20 && n <= 34, 1'b1)
        repeat (2) @(negedge clk_sys);
        `CHK(emcy_cnt[0] - e0, 1)
        open_load[0] = 1'b0;
        wait_for(2, 0, 16'h0000, 5, n);
        od(1'b1, `VHF_IDX_FAULT_EN, 8'h01, 16'h0000, 1'b0, 16'h0000);
        e0 = emcy_cnt[0];
        open_load[0] = 1'b1;
        wait_for(2, 0, 16'h0001, 45, n);
        repeat (2) @(negedge clk_sys);
        `CHK(emcy_cnt[0] - e0, 0)
        `CHK(emcy_cnt[1], 0)
        open_load[0] = 1'b0;
        ctrl_target[0] = 16'sh0000;
        $display("t_fault done");
    endtask

    initial begin
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        t_defaults();
        t_ranges();
        t_hotshot();
        t_blink();
        t_override();
        t_fault();
        end_sim();
    end
endmodule
